// ---- core/cfg_bridge_regs.svh ----
`ifndef CFG_BRIDGE_REGS_SVH
`define CFG_BRIDGE_REGS_SVH
`define CFG_ADDR_PORT 16'h0cf8
`define CFG_DATA_PORT 16'h0cfc
`define CFG_ADDR_RESET 32'h0000_0000
`define CFG_ADDR_WMASK 32'h80ff_fffc
`define CFG_EN_BIT 31
`define CFG_BUS_HI 23
`define CFG_BUS_LO 16
`define CFG_DEV_HI 15
`define CFG_DEV_LO 11
`define CFG_FUN_HI 10
`define CFG_FUN_LO 8
`define CFG_REG_HI 7
`define CFG_REG_LO 2
`define OWN_BUS 8'h00
`define OWN_DEV 5'h05
`define OWN_FUN 3'h0
`define OWN_IDSEL_BIT 16
`define IDX_PORT 16'h0022
`define IDX_DATA_PORT 16'h0023
`endif

// ---- core/cfg_bridge_pkg.sv ----
package cfg_bridge_pkg;
  typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_DWORD} io_size_t;
  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] port;
    io_size_t size;
    logic [31:0] wdata;
  } io_req_t;
  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
    logic [3:0] be_n;
    logic [31:0] wdata;
    logic own;
  } cfg_cyc_t;
  typedef enum logic [1:0] {SPACE_NONE, SPACE_PCI_CFG, SPACE_INDEXED, SPACE_LEGACY} io_space_t;
endpackage

// ---- core/cfg_byte_enable.sv ----
`timescale 1ns/100ps
module cfg_byte_enable
  import cfg_bridge_pkg::*;
(
  input wire [1:0] offset_in,
  input wire io_size_t size_in,
  output logic [3:0] be_n_out
);
  logic [3:0] be;
  always_comb
  begin
    unique case (size_in)
      SZ_BYTE: be = 4'h1 << offset_in;
      SZ_WORD: be = offset_in[1] ? 4'hc : 4'h3;
      default: be = 4'hf;
    endcase
    // pci enables are active low
    be_n_out = ~be;
  end
endmodule

// ---- core/cfg_strap_latch.sv ----
`timescale 1ns/100ps
module cfg_strap_latch
(
  input wire mclk_in,
  input wire rst_in,
  input wire rtc_source_strap_in,
  input wire row_strobe_pin_strap_in,
  output logic internal_rtc_out,
  output logic extra_row_strobes_out
);
  logic armed_r, armed_nxt;
  logic rtc_r, rtc_nxt;
  logic ras_r, ras_nxt;
  // straps caught on the first clock after reset release, never under reset
  always_comb
  begin
    armed_nxt = armed_r;
    rtc_nxt = rtc_r;
    ras_nxt = ras_r;
    if (armed_r)
    begin
      rtc_nxt = rtc_source_strap_in;
      ras_nxt = row_strobe_pin_strap_in;
      armed_nxt = 1'b0;
    end
  end
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      armed_r <= 1'b1;
      rtc_r <= 1'b0;
      ras_r <= 1'b0;
    end
    else
    begin
      armed_r <= armed_nxt;
      rtc_r <= rtc_nxt;
      ras_r <= ras_nxt;
    end
  end
  assign internal_rtc_out = rtc_r;
  assign extra_row_strobes_out = ras_r;
endmodule

// ---- core/pci_config_access_ports.sv ----
`timescale 1ns/100ps
`include "cfg_bridge_regs.svh"
// Summary of operation
// - Reset loads all registers with defaults and the address port with zero.
// - I/O space splits into config ports, an indexed pair at 22/23, and legacy ports.
// - A strap high at power-up picks the internal clock-calendar, low the external one.
// - A second strap high makes two shared pins row strobes, low makes them lock/back-off.
// - The address port is a 32-bit register of enable, reserved, bus, device, function, reg.
// - The enable flag at 1 lets the data port issue config cycles, at 0 blocks them.
// - A full doubleword write to 0cf8 latches the value with reserved bits 30:24 and bits 1:0 cleared.
// - A full doubleword read of 0cf8 returns the held address.
// - With the enable flag set, any access within 0cfc..0cff becomes a config cycle to the latched address.
// - Byte enables follow the size and byte offset of the data port access.
// - The bridge claims bus 0, device 5 (idsel ad16), function 0, for both chips.
module pci_config_access_ports
  import cfg_bridge_pkg::*;
(
  input wire mclk_in,
  input wire rst_in,
  input wire io_req_t io_req_in,
  input wire cfg_done_in,
  input wire [31:0] cfg_rdata_in,
  input wire rtc_source_strap_in,
  input wire row_strobe_pin_strap_in,
  output logic io_done_out,
  output logic [31:0] io_rdata_out,
  output logic io_pass_out,
  output io_space_t io_space_out,
  output cfg_cyc_t cfg_cyc_out,
  output logic [15:0] cfg_idsel_out,
  output logic internal_rtc_out,
  output logic extra_row_strobes_out
);
  typedef enum {ST_IDLE, ST_CFG} state_t;
  state_t state_r, state_nxt;
  logic [31:0] cfg_addr_r, cfg_addr_nxt;
  cfg_cyc_t cyc_r, cyc_nxt;
  logic done_r, done_nxt;
  logic pass_r, pass_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  io_space_t space_r, space_nxt;
  logic [15:0] idsel_r, idsel_nxt;
  logic [3:0] be_n;
  logic hit_addr, hit_data, own_target;

  function automatic logic is_own(input logic [31:0] a);
    is_own = (a[`CFG_BUS_HI:`CFG_BUS_LO] == `OWN_BUS) &&
             (a[`CFG_DEV_HI:`CFG_DEV_LO] == `OWN_DEV) &&
             (a[`CFG_FUN_HI:`CFG_FUN_LO] == `OWN_FUN);
  endfunction

  // lowest enabled lane; a word at an odd port still sits in lane 0 or 2
  function automatic logic [4:0] lane_shift(input logic [3:0] be_n_f);
    if (!be_n_f[0])
      lane_shift = 5'h00;
    else if (!be_n_f[1])
      lane_shift = 5'h08;
    else if (!be_n_f[2])
      lane_shift = 5'h10;
    else
      lane_shift = 5'h18;
  endfunction

  function automatic logic [31:0] lane_mask(input logic [3:0] be_n_f);
    lane_mask = {{8{~be_n_f[3]}}, {8{~be_n_f[2]}}, {8{~be_n_f[1]}}, {8{~be_n_f[0]}}};
  endfunction

  cfg_byte_enable u_be
  (
    .offset_in(io_req_in.port[1:0]),
    .size_in(io_req_in.size),
    .be_n_out(be_n)
  );

  cfg_strap_latch u_strap
  (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .rtc_source_strap_in(rtc_source_strap_in),
    .row_strobe_pin_strap_in(row_strobe_pin_strap_in),
    .internal_rtc_out(internal_rtc_out),
    .extra_row_strobes_out(extra_row_strobes_out)
  );

  assign hit_addr = io_req_in.port == `CFG_ADDR_PORT;
  assign hit_data = io_req_in.port[15:2] == `CFG_DATA_PORT >> 2;
  assign own_target = is_own(cfg_addr_r);

  always_comb
  begin
    state_nxt = state_r;
    cfg_addr_nxt = cfg_addr_r;
    cyc_nxt = cyc_r;
    done_nxt = 1'b0;
    pass_nxt = 1'b0;
    rdata_nxt = rdata_r;
    space_nxt = space_r;
    idsel_nxt = idsel_r;
    unique case (state_r)
      ST_IDLE:
        if (io_req_in.valid)
        begin
          if (hit_addr && io_req_in.size == SZ_DWORD)
          begin
            space_nxt = SPACE_PCI_CFG;
            done_nxt = 1'b1;
            if (io_req_in.write)
              cfg_addr_nxt = io_req_in.wdata & `CFG_ADDR_WMASK;
            else
              rdata_nxt = cfg_addr_r;
          end
          else if (hit_data && cfg_addr_r[`CFG_EN_BIT])
          begin
            space_nxt = SPACE_PCI_CFG;
            cyc_nxt.valid = 1'b1;
            cyc_nxt.write = io_req_in.write;
            cyc_nxt.addr = {cfg_addr_r[31:2], 2'b00};
            cyc_nxt.be_n = be_n;
            cyc_nxt.wdata = io_req_in.wdata << lane_shift(be_n);
            cyc_nxt.own = own_target;
            idsel_nxt = own_target ? 16'h0001 : 16'h0000;
            state_nxt = ST_CFG;
          end
          else
          begin
            // disabled data port and partial 0cf8 go out as plain i/o
            pass_nxt = 1'b1;
            done_nxt = 1'b1;
            if (io_req_in.port == `IDX_PORT || io_req_in.port == `IDX_DATA_PORT)
              space_nxt = SPACE_INDEXED;
            else
              space_nxt = SPACE_LEGACY;
          end
        end
      ST_CFG:
        if (cfg_done_in)
        begin
          cyc_nxt.valid = 1'b0;
          idsel_nxt = 16'h0000;
          done_nxt = 1'b1;
          // unused lanes dropped so narrow reads come back zero-extended
          rdata_nxt = (cfg_rdata_in & lane_mask(cyc_r.be_n)) >> lane_shift(cyc_r.be_n);
          state_nxt = ST_IDLE;
        end
    endcase
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      state_r <= ST_IDLE;
      cfg_addr_r <= `CFG_ADDR_RESET;
      cyc_r <= '0;
      done_r <= 1'b0;
      pass_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      space_r <= SPACE_NONE;
      idsel_r <= 16'h0000;
    end
    else
    begin
      state_r <= state_nxt;
      cfg_addr_r <= cfg_addr_nxt;
      cyc_r <= cyc_nxt;
      done_r <= done_nxt;
      pass_r <= pass_nxt;
      rdata_r <= rdata_nxt;
      space_r <= space_nxt;
      idsel_r <= idsel_nxt;
    end
  end

  assign io_done_out = done_r;
  assign io_pass_out = pass_r;
  assign io_rdata_out = rdata_r;
  assign io_space_out = space_r;
  assign cfg_cyc_out = cyc_r;
  // idsel vector bit 0 stands for ad16
  assign cfg_idsel_out = idsel_r;

  addr_reset_a: assert property (@(posedge mclk_in) rst_in |=> cfg_addr_r == 32'h0)
    else $error("address port not zero after reset");
  addr_latch_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    state_r == ST_IDLE && io_req_in.valid && io_req_in.write && hit_addr &&
    io_req_in.size == SZ_DWORD |=> cfg_addr_r == ($past(io_req_in.wdata) & 32'h80ff_fffc))
    else $error("address port not latched");
  addr_read_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    state_r == ST_IDLE && io_req_in.valid && !io_req_in.write && hit_addr &&
    io_req_in.size == SZ_DWORD |=> io_done_out && io_rdata_out == $past(cfg_addr_r))
    else $error("address read wrong");
  partial_keep_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    state_r == ST_IDLE && io_req_in.valid && hit_addr && io_req_in.size != SZ_DWORD
    |=> $stable(cfg_addr_r) && io_pass_out)
    else $error("partial access altered address");
  cyc_start_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    state_r == ST_IDLE && io_req_in.valid && hit_data && cfg_addr_r[31]
    |=> cfg_cyc_out.valid && cfg_cyc_out.addr[31:2] == $past(cfg_addr_r[31:2]))
    else $error("config cycle not started");
  enable_gate_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    state_r == ST_IDLE && io_req_in.valid && hit_data && !cfg_addr_r[31]
    |=> !cfg_cyc_out.valid && io_pass_out)
    else $error("disabled data port made a cycle");
  word_be_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    state_r == ST_IDLE && io_req_in.valid && hit_data && cfg_addr_r[31] &&
    io_req_in.size == SZ_WORD && io_req_in.port[1] |=> cfg_cyc_out.be_n == 4'h3)
    else $error("word byte enables wrong");
  own_claim_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    cfg_cyc_out.valid |-> cfg_cyc_out.own == (cfg_cyc_out.addr[23:8] == 16'h0028))
    else $error("own target claim wrong");

  rst_quiet_a: assert property (@(posedge mclk_in) rst_in |=>
    !io_done_out && !io_pass_out && !cfg_cyc_out.valid && io_space_out == SPACE_NONE)
    else $error("outputs not idle after reset");
  addr_hold_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    !(state_r == ST_IDLE && io_req_in.valid && io_req_in.write && hit_addr &&
    io_req_in.size == SZ_DWORD) |=> $stable(cfg_addr_r))
    else $error("address port changed without write");
  pass_pair_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    io_pass_out |-> io_done_out)
    else $error("pass without done");

  // straps freeze after the first edge out of reset, later pin noise is harmless
  rtc_strap_a: assert property (@(posedge mclk_in) rst_in ##1 !rst_in |=>
    internal_rtc_out == $past(rtc_source_strap_in))
    else $error("clock source strap not taken");
  row_strap_a: assert property (@(posedge mclk_in) rst_in ##1 !rst_in |=>
    extra_row_strobes_out == $past(row_strobe_pin_strap_in))
    else $error("row strobe strap not taken");
  strap_hold_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    !$past(rst_in) && !$past(rst_in, 2) |-> $stable({internal_rtc_out, extra_row_strobes_out}))
    else $error("strap value moved");

  byte_be_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    state_r == ST_IDLE && io_req_in.valid && hit_data && cfg_addr_r[31] &&
    io_req_in.size == SZ_BYTE |=> cfg_cyc_out.be_n == ~(4'h1 << $past(io_req_in.port[1:0])))
    else $error("byte enables wrong");
  word_lo_be_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    state_r == ST_IDLE && io_req_in.valid && hit_data && cfg_addr_r[31] &&
    io_req_in.size == SZ_WORD && !io_req_in.port[1] |=> cfg_cyc_out.be_n == 4'hc)
    else $error("low word byte enables wrong");
  dword_be_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    state_r == ST_IDLE && io_req_in.valid && hit_data && cfg_addr_r[31] &&
    io_req_in.size == SZ_DWORD |=> cfg_cyc_out.be_n == 4'h0)
    else $error("dword byte enables wrong");
  byte_lane_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    state_r == ST_IDLE && io_req_in.valid && io_req_in.write && hit_data &&
    cfg_addr_r[31] && io_req_in.size == SZ_BYTE |=>
    ((cfg_cyc_out.wdata >> {$past(io_req_in.port[1:0]), 3'b000}) & 32'h0000_00ff) ==
    {24'h00_0000, $past(io_req_in.wdata[7:0])})
    else $error("byte write lane wrong");
  word_lane_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    state_r == ST_IDLE && io_req_in.valid && io_req_in.write && hit_data &&
    cfg_addr_r[31] && io_req_in.size == SZ_WORD && io_req_in.port[1] |=>
    cfg_cyc_out.wdata[31:16] == $past(io_req_in.wdata[15:0]))
    else $error("high word write lane wrong");
  dword_lane_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    state_r == ST_IDLE && io_req_in.valid && io_req_in.write && hit_data &&
    cfg_addr_r[31] && io_req_in.size == SZ_DWORD |=> cfg_cyc_out.wdata == $past(io_req_in.wdata))
    else $error("dword write data wrong");
  rd_byte_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    state_r == ST_CFG && cfg_done_in && !cfg_cyc_out.write && cfg_cyc_out.be_n == 4'hb
    |=> io_rdata_out == {24'h00_0000, $past(cfg_rdata_in[23:16])})
    else $error("byte read lane wrong");
  rd_word_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    state_r == ST_CFG && cfg_done_in && !cfg_cyc_out.write && cfg_cyc_out.be_n == 4'h3
    |=> io_rdata_out == {16'h0000, $past(cfg_rdata_in[31:16])})
    else $error("high word read lane wrong");
  rd_dword_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    state_r == ST_CFG && cfg_done_in && !cfg_cyc_out.write && cfg_cyc_out.be_n == 4'h0
    |=> io_rdata_out == $past(cfg_rdata_in))
    else $error("dword read data wrong");

  cyc_dir_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    state_r == ST_IDLE && io_req_in.valid && hit_data && cfg_addr_r[31]
    |=> cfg_cyc_out.write == $past(io_req_in.write) && state_r == ST_CFG)
    else $error("config cycle direction wrong");
  cyc_hold_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    state_r == ST_CFG && !cfg_done_in |=> $stable(cfg_cyc_out) && $stable(cfg_addr_r))
    else $error("config cycle moved while outstanding");
  cyc_end_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    state_r == ST_CFG && cfg_done_in |=> !cfg_cyc_out.valid && io_done_out &&
    cfg_idsel_out == 16'h0000)
    else $error("config cycle not closed");
  idsel_track_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    cfg_idsel_out == {15'h0000, cfg_cyc_out.valid && cfg_cyc_out.own})
    else $error("idsel does not follow own cycle");

  space_idx_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    state_r == ST_IDLE && io_req_in.valid &&
    (io_req_in.port == `IDX_PORT || io_req_in.port == `IDX_DATA_PORT)
    |=> io_space_out == SPACE_INDEXED && io_pass_out)
    else $error("indexed pair not flagged");
  space_cfg_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    state_r == ST_IDLE && io_req_in.valid &&
    ((hit_addr && io_req_in.size == SZ_DWORD) || (hit_data && cfg_addr_r[31]))
    |=> io_space_out == SPACE_PCI_CFG)
    else $error("config space not flagged");
  space_legacy_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    state_r == ST_IDLE && io_req_in.valid && !hit_addr && !hit_data &&
    io_req_in.port != `IDX_PORT && io_req_in.port != `IDX_DATA_PORT
    |=> io_space_out == SPACE_LEGACY && io_pass_out)
    else $error("legacy space not flagged");
endmodule

// ---- bench/cfg_target_model.sv ----
`timescale 1ns/100ps
module cfg_target_model
  import cfg_bridge_pkg::*;
(
  input wire mclk_in,
  input wire rst_in,
  input wire cfg_cyc_t cyc_in,
  input wire [3:0] lat_in,
  output logic done_out,
  output logic [31:0] rdata_out
);
  logic [31:0] mem [logic [31:0]];
  logic [31:0] v;
  int cnt;
  logic ans;
  initial
  begin
    rdata_out = '0;
    done_out = 1'b0;
  end
  always @(posedge mclk_in)
  begin
    done_out <= 1'b0;
    // idle data inverts every clock, so the cycle after an answer never repeats it
    rdata_out <= ~rdata_out;
    if (rst_in || !cyc_in.valid)
    begin
      cnt = 0;
      ans = 0;
    end
    else if (!ans && cnt++ >= lat_in)
    begin
      ans = 1;
      if (!mem.exists(cyc_in.addr))
        mem[cyc_in.addr] = cyc_in.addr ^ 32'h5a5aa5a5;
      v = mem[cyc_in.addr];
      for (int b = 0; b < 4; b++)
        if (cyc_in.write && !cyc_in.be_n[b])
          v[8*b+:8] = cyc_in.wdata[8*b+:8];
      mem[cyc_in.addr] = v;
      done_out <= 1'b1;
      rdata_out <= v;
    end
  end
endmodule

// ---- bench/pci_config_access_ports_tb.sv ----
`timescale 1ns/100ps
`include "cfg_bridge_regs.svh"
module pci_config_access_ports_tb
  import cfg_bridge_pkg::*;
;
  logic mclk_in = 0, rst_in = 1, done, pas, isel, io_done_out, io_pass_out;
  logic internal_rtc_out, extra_row_strobes_out;
  logic [31:0] rdata, rd, ref_a, io_rdata_out, seed = 32'h2995;
  logic [15:0] cfg_idsel_out;
  logic [3:0] lat = 0;
  logic [1:0] st;
  io_req_t io_req_in = '0;
  cfg_cyc_t cyc, cfg_cyc_out;
  io_space_t sp, io_space_out;
  logic [31:0] mem [logic [31:0]];
  int n_fail = 0, cmp_count = 0;
  pci_config_access_ports i_dut (.mclk_in(mclk_in), .rst_in(rst_in),
    .io_req_in(io_req_in), .cfg_done_in(done), .cfg_rdata_in(rdata),
    .rtc_source_strap_in(st[0]), .row_strobe_pin_strap_in(st[1]),
    .io_done_out(io_done_out), .io_rdata_out(io_rdata_out), .io_pass_out(io_pass_out),
    .io_space_out(io_space_out), .cfg_cyc_out(cfg_cyc_out), .cfg_idsel_out(cfg_idsel_out),
    .internal_rtc_out(internal_rtc_out), .extra_row_strobes_out(extra_row_strobes_out));
  cfg_target_model i_tgt (.mclk_in(mclk_in), .rst_in(rst_in), .cyc_in(cfg_cyc_out),
    .lat_in(lat), .done_out(done), .rdata_out(rdata));
  initial forever #50 mclk_in = ~mclk_in;
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task close_out;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task io(input logic w, input logic [15:0] p, input io_size_t s, input logic [31:0] d);
    int i;
    @(posedge mclk_in);
    io_req_in <= '{1'b1, w, p, s, d};
    @(posedge mclk_in);
    io_req_in.valid <= 1'b0;
    cyc = '0;
    isel = 0;
    i = 0;
    do
    begin
      @(negedge mclk_in);
      if (cfg_cyc_out.valid === 1'b1)
      begin
        cyc = cfg_cyc_out;
        isel = cfg_idsel_out[0];
      end
      i++;
    end while (io_done_out !== 1'b1 && i < 60);
    if (i >= 60)
      n_fail++;
    rd = io_rdata_out;
    pas = io_pass_out;
    sp = io_space_out;
  endtask
  task wa(input logic [31:0] d);
    io(1, `CFG_ADDR_PORT, SZ_DWORD, d);
    ref_a = d & `CFG_ADDR_WMASK;
  endtask
  task dp(input logic w, input logic [1:0] o, input io_size_t s);
    logic [31:0] d, m, key;
    logic [3:0] bm;
    int sh;
    sh = s == SZ_DWORD ? 0 : s == SZ_WORD ? 16 * o[1] : 8 * o;
    m = s == SZ_BYTE ? 32'hff : s == SZ_WORD ? 32'hffff : 32'hffffffff;
    bm = s == SZ_BYTE ? 4'h1 : s == SZ_WORD ? 4'h3 : 4'hf;
    d = rnd() & m;
    io(w, `CFG_DATA_PORT + 16'(o), s, d);
    key = ref_a;
    if (!ref_a[31])
    begin
      chk(pas, 1);
      return;
    end
    if (!mem.exists(key))
      mem[key] = key ^ 32'h5a5aa5a5;
    chk({cyc.addr[30:0], cyc.write}, {key[30:0], w});
    chk(cyc.be_n, 4'(~(bm << (sh / 8))));
    chk({cyc.own, isel, sp}, {2{key[23:8] == 16'h0028}} << 2 | SPACE_PCI_CFG);
    if (w)
    begin
      chk(cyc.wdata & (m << sh), d << sh);
      mem[key] = (mem[key] & ~(m << sh)) | (d << sh);
    end
    else
      chk(rd, (mem[key] >> sh) & m);
  endtask
  initial
  begin
    #(100 * 30000);
    n_fail++;
    close_out;
  end
  initial
  begin
    st = 2'(rnd());
    repeat (20) @(posedge mclk_in);
    rst_in <= 0;
    repeat (3) @(posedge mclk_in);
    @(negedge mclk_in);
    chk(internal_rtc_out, st[0]);
    chk(extra_row_strobes_out, st[1]);
    io(0, `CFG_ADDR_PORT, SZ_DWORD, 0);
    chk(rd, 0);
    repeat (4)
    begin
      wa(rnd());
      io(0, `CFG_ADDR_PORT, SZ_DWORD, 0);
      chk(rd, ref_a);
    end
    io(1, `CFG_ADDR_PORT, SZ_WORD, rnd());
    chk(pas, 1);
    io(0, `CFG_ADDR_PORT, SZ_DWORD, 0);
    chk(rd, ref_a);
    $display("address port test done");
    wa(32'h00002840);
    dp(0, 0, SZ_BYTE);
    for (int k = 0; k < 12; k++)
    begin
      // half the rounds hit the bridge itself, half some other target
      wa(k < 6 ? 32'h80002840 | (rnd() & 32'hfc) : rnd() | 32'h80000000);
      lat = 4'(rnd() % 6);
      for (int j = 0; j < 12; j++)
      begin
        dp(1, 2'(j), io_size_t'(j / 4));
        dp(0, 2'(j), io_size_t'(j / 4));
      end
    end
    $display("data port test done");
    io(0, `IDX_PORT, SZ_BYTE, 0);
    chk(sp, SPACE_INDEXED);
    io(0, `IDX_DATA_PORT, SZ_BYTE, 0);
    chk(sp, SPACE_INDEXED);
    io(0, 16'h0080, SZ_BYTE, 0);
    chk(sp, SPACE_LEGACY);
    @(posedge mclk_in);
    rst_in <= 1;
    st <= ~st;
    repeat (2) @(posedge mclk_in);
    rst_in <= 0;
    io(0, `CFG_ADDR_PORT, SZ_DWORD, 0);
    chk(rd, 0);
    chk(internal_rtc_out, st[0]);
    chk(extra_row_strobes_out, st[1]);
    $display("space and reset test done");
    close_out;
  end
endmodule
